// >>> verilog/clk_gate_ctrl.sv
// Peripheral clock gating and high-frequency oscillator control
`timescale 1ns/1ps
module clk_gate_ctrl
  import clk_gate_pkg::*;
#(
  parameter int NGROUPS       = NUM_GROUPS,
  parameter int SETTLE_CYCLES = HF_OSC_SETTLE_CYCLES,
  parameter logic [6:0] CAL_TRIM = CAL_TRIM_RESET
) (
  // Clock, reset, enable
  input  wire logic               clk_in,
  input  wire logic               nrst_in,
  input  wire logic               ce_in,
  // Special function register port
  input  wire logic [7:0]         sfr_addr_in,
  input  wire logic [7:0]         sfr_wdata_in,
  input  wire logic               sfr_wr_in,
  input  wire logic               sfr_rd_in,
  output logic      [7:0]         sfr_rdata_out,
  // Core power state
  input  wire logic               core_idle_in,
  input  wire logic               clk_req_in,
  input  wire logic               scan_en_in,
  // Gated peripheral clocks and status
  output logic      [NGROUPS-1:0] periph_clk_out,
  output logic      [NGROUPS-1:0] periph_clk_en_out,
  output logic                    lp_active_out,
  output logic                    lp_idle_out,
  output logic                    src_clk_req_out,
  // Oscillator controls
  output logic                    hf_osc_enable_out,
  output logic                    spread_spectrum_enable_out,
  output logic      [CAL_MSB:0]   hf_osc_cal_out,
  input  wire logic               hf_osc_locked_in
);
  logic       rst_sync1_q;
  logic       rst_sync2_q;
  logic       rst_n;
  logic [7:0] lowpower_periph_clock_enable_q;
  logic [7:0] clock_gating_mode_q;
  logic       sse_q;
  logic [6:0] cal_q;
  logic       osc_en_q;
  logic [5:0] osc_rsvd_q;
  logic       ready_q;
  logic [15:0] settle_q;
  logic [7:0] rdata_q;
  logic       wr_lowpower_periph_clock_enable;
  logic       wr_clock_gating_mode;
  logic       wr_cal;
  logic       wr_osc;
  logic       lp_en;
  logic       force_tree;
  power_mode_e mode;
  logic [NGROUPS-1:0] active_en;
  logic [NGROUPS-1:0] idle_en;
  logic [NGROUPS-1:0] grp_en_d;
  logic [NGROUPS-1:0] grp_en_q;

  // Address match helper
  function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
    return a == target;
  endfunction : hit

  // Reset release through two flops
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rst_sync1_q <= 1'b0;
      rst_sync2_q <= 1'b0;
    end else begin
      rst_sync1_q <= 1'b1;
      rst_sync2_q <= rst_sync1_q;
    end
  end
  assign rst_n = rst_sync2_q;

  // Write strobes
  assign wr_lowpower_periph_clock_enable  = ce_in & sfr_wr_in & hit(sfr_addr_in, ADDR_LP_PERIPH_CLK_EN);
  assign wr_clock_gating_mode = ce_in & sfr_wr_in & hit(sfr_addr_in, ADDR_CLOCK_GATING_MODE);
  assign wr_cal     = ce_in & sfr_wr_in & hit(sfr_addr_in, ADDR_HF_OSC_CALIBRATION);
  assign wr_osc     = ce_in & sfr_wr_in & hit(sfr_addr_in, ADDR_HF_OSC_CONTROL);

  // Peripheral enable register
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      lowpower_periph_clock_enable_q <= LOWPOWER_PERIPH_CLOCK_ENABLE_RESET;
    end else if (wr_lowpower_periph_clock_enable) begin
      lowpower_periph_clock_enable_q <= sfr_wdata_in;
    end
  end

  // Clock mode register; reserved bits held at reset value
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      clock_gating_mode_q <= CLOCK_GATING_MODE_RESET;
    end else if (wr_clock_gating_mode) begin
      clock_gating_mode_q <= CLOCK_GATING_MODE_RESET;
      clock_gating_mode_q[LOW_POWER_MODE_ENABLE_BIT] <= sfr_wdata_in[LOW_POWER_MODE_ENABLE_BIT];
      clock_gating_mode_q[CLOCK_REQUEST_ENABLE_BIT]  <= sfr_wdata_in[CLOCK_REQUEST_ENABLE_BIT];
      clock_gating_mode_q[FORCE_CLOCK_TREE_BIT]      <= sfr_wdata_in[FORCE_CLOCK_TREE_BIT];
    end
  end

  // Calibration register
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      sse_q <= 1'b0;
      cal_q <= CAL_TRIM;
    end else if (wr_cal) begin
      sse_q <= sfr_wdata_in[SPREAD_SPECTRUM_ENABLE_BIT];
      cal_q <= sfr_wdata_in[CAL_MSB:0];
    end
  end

  // Oscillator control register; reserved bits are plain storage
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      osc_en_q   <= 1'b0;
      osc_rsvd_q <= OSCCTL_RSVD_RESET;
    end else if (wr_osc) begin
      osc_en_q   <= sfr_wdata_in[HF_OSC_ENABLE_BIT];
      osc_rsvd_q <= sfr_wdata_in[5:0];
    end
  end

  // Ready flag: settle counter after enable or recalibration
  // Any calibration write restarts settling since the frequency moves
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      settle_q <= 16'h0000;
      ready_q  <= 1'b0;
    end else if (ce_in) begin
      if (!osc_en_q || wr_cal) begin
        settle_q <= 16'h0000;
        ready_q  <= 1'b0;
      end else if (settle_q < 16'(SETTLE_CYCLES)) begin
        settle_q <= settle_q + 16'h0001;
        ready_q  <= 1'b0;
      end else begin
        ready_q  <= hf_osc_locked_in;
      end
    end
  end

  // Mode decode
  assign lp_en      = clock_gating_mode_q[LOW_POWER_MODE_ENABLE_BIT];
  assign force_tree = clock_gating_mode_q[FORCE_CLOCK_TREE_BIT];
  always_comb begin
    if (lp_en) begin
      mode = core_idle_in ? PM_LP_IDLE : PM_LP_ACTIVE;
    end else begin
      mode = core_idle_in ? PM_IDLE : PM_ACTIVE;
    end
  end

  // Group enables per mode
  // active group 3
  assign active_en[3] = lowpower_periph_clock_enable_q[LP_ACTIVE_GROUP3_EN_BIT];
  assign active_en[2] = lowpower_periph_clock_enable_q[LP_ACTIVE_GROUP2_EN_BIT];
  assign active_en[1] = lowpower_periph_clock_enable_q[LP_ACTIVE_GROUP1_EN_BIT];
  assign active_en[0] = lowpower_periph_clock_enable_q[LP_ACTIVE_GROUP0_EN_BIT];
  assign idle_en[3]   = lowpower_periph_clock_enable_q[LP_IDLE_GROUP3_EN_BIT];
  assign idle_en[2]   = lowpower_periph_clock_enable_q[LP_IDLE_GROUP2_EN_BIT];
  assign idle_en[1]   = lowpower_periph_clock_enable_q[LP_IDLE_GROUP1_EN_BIT];
  assign idle_en[0]   = lowpower_periph_clock_enable_q[LP_IDLE_GROUP0_EN_BIT];

  // Select enables from mode
  always_comb begin
    unique case (mode)
      PM_ACTIVE:    grp_en_d = '1;
      PM_IDLE:      grp_en_d = '1;
      PM_LP_ACTIVE: grp_en_d = force_tree ? '1 : active_en;
      PM_LP_IDLE:   grp_en_d = idle_en;
    endcase
  end

  // Registered enables feed the gate cells
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      grp_en_q <= '1;
    end else if (ce_in) begin
      grp_en_q <= grp_en_d;
    end
  end

  for (genvar g = 0; g < NGROUPS; g++) begin : g_gate
    glitch_free_gate i_glitch_free_gate (
      .clk_in     (clk_in),
      .en_in      (grp_en_q[g]),
      .test_en_in (scan_en_in),
      .gclk_out   (periph_clk_out[g])
    );
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      src_clk_req_out <= 1'b1;
    end else if (ce_in) begin
      if (clock_gating_mode_q[CLOCK_REQUEST_ENABLE_BIT]) begin
        src_clk_req_out <= clk_req_in | (|grp_en_d);
      end else begin
        src_clk_req_out <= 1'b1;
      end
    end
  end

  // Read data; unmapped addresses read zero
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= READ_ZERO;
    end else if (ce_in && sfr_rd_in) begin
      if (hit(sfr_addr_in, ADDR_LP_PERIPH_CLK_EN)) begin
        rdata_q <= lowpower_periph_clock_enable_q;
      end else if (hit(sfr_addr_in, ADDR_CLOCK_GATING_MODE)) begin
        rdata_q <= clock_gating_mode_q;
      end else if (hit(sfr_addr_in, ADDR_HF_OSC_CALIBRATION)) begin
        rdata_q <= {sse_q, cal_q};
      end else if (hit(sfr_addr_in, ADDR_HF_OSC_CONTROL)) begin
        rdata_q <= {osc_en_q, ready_q, osc_rsvd_q};
      end else begin
        rdata_q <= READ_ZERO;
      end
    end
  end

  // Outputs
  assign sfr_rdata_out              = rdata_q;
  assign periph_clk_en_out          = grp_en_q;
  assign lp_active_out              = (mode == PM_LP_ACTIVE);
  assign lp_idle_out                = (mode == PM_LP_IDLE);
  assign hf_osc_enable_out          = osc_en_q;
  assign spread_spectrum_enable_out = sse_q;
  assign hf_osc_cal_out             = cal_q;
endmodule : clk_gate_ctrl

// >>> verilog/clk_gate_pkg.sv
// Constants for the peripheral clock gating and oscillator control block
// Behaviour
// - active bit 7 gates group 3 clocks
// - active bit 6 gates group 2 clocks
// - active bit 5 gates group 1 clock
// - active bit 4 gates group 0 clocks
// - idle bit 3 gates group 3 clocks
// - idle bit 2 gates group 2 clocks
// - idle bit 1 gates group 1 clock
// - idle bit 0 gates group 0 clocks
// - low-power modes only with enable bit set
// - group enables ignored while low power off
// - request clocks only when needed, if enabled
// - force tree runs all groups only in low-power active mode
// - registers stay reachable in active mode
// - bit 7 enables oscillator dithering, resets 0
// - calibration field sets oscillator period
// - calibration resets to factory trim value
// - bit 7 enables oscillator, resets 0
// - ready bit shows oscillator at frequency
package clk_gate_pkg;
  // Register addresses
  localparam logic [7:0] ADDR_HF_OSC_CALIBRATION = 8'hAF;
  localparam logic [7:0] ADDR_HF_OSC_CONTROL     = 8'hB2;
  localparam logic [7:0] ADDR_LP_PERIPH_CLK_EN   = 8'hF6;
  localparam logic [7:0] ADDR_CLOCK_GATING_MODE  = 8'hF7;
  // Peripheral enable fields
  localparam int LP_ACTIVE_GROUP3_EN_BIT = 7;
  localparam int LP_ACTIVE_GROUP2_EN_BIT = 6;
  localparam int LP_ACTIVE_GROUP1_EN_BIT = 5;
  localparam int LP_ACTIVE_GROUP0_EN_BIT = 4;
  localparam int LP_IDLE_GROUP3_EN_BIT   = 3;
  localparam int LP_IDLE_GROUP2_EN_BIT   = 2;
  localparam int LP_IDLE_GROUP1_EN_BIT   = 1;
  localparam int LP_IDLE_GROUP0_EN_BIT   = 0;
  localparam int NUM_GROUPS              = 4;
  // Clock mode fields
  localparam int LOW_POWER_MODE_ENABLE_BIT = 2;
  localparam int CLOCK_REQUEST_ENABLE_BIT  = 1;
  localparam int FORCE_CLOCK_TREE_BIT      = 0;
  // Oscillator fields
  localparam int SPREAD_SPECTRUM_ENABLE_BIT = 7;
  localparam int CAL_MSB                    = 6;
  localparam int HF_OSC_ENABLE_BIT          = 7;
  localparam int HF_OSC_READY_BIT           = 6;
  // Reset values
  localparam logic [7:0] LOWPOWER_PERIPH_CLOCK_ENABLE_RESET   = 8'h00;
  localparam logic [7:0] CLOCK_GATING_MODE_RESET  = 8'h00;
  localparam logic [6:0] CAL_TRIM_RESET = 7'h40;
  localparam logic [5:0] OSCCTL_RSVD_RESET = 6'h00;
  localparam logic [7:0] READ_ZERO      = 8'h00;
  // Oscillator settling time before ready
  localparam int    HF_OSC_SETTLE_NS    = 2000;
  localparam int    CLK_PERIOD_NS       = 10;
  localparam int    HF_OSC_SETTLE_CYCLES = (HF_OSC_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Power mode of the core
  typedef enum logic [1:0] {
    PM_ACTIVE    = 2'b00,
    PM_IDLE      = 2'b01,
    PM_LP_ACTIVE = 2'b10,
    PM_LP_IDLE   = 2'b11
  } power_mode_e;
endpackage : clk_gate_pkg

// >>> verilog/glitch_free_gate.sv
// Glitch-free clock gate cell for one peripheral group
`timescale 1ns/1ps
module glitch_free_gate (
  // Clock and enable
  input  wire logic clk_in,
  input  wire logic en_in,
  input  wire logic test_en_in,
  // Gated clock
  output logic      gclk_out
);
  logic latch_q;

  // latch on low phase
  // Enable only changes while the clock is low, so no runt pulse
  always_latch begin
    if (!clk_in) begin
      latch_q = en_in | test_en_in;
    end
  end

  assign gclk_out = clk_in & latch_q;
endmodule : glitch_free_gate

// >>> test/clk_gate_ctrl_sva.sv
// Port-level assertions for the clock gating block
`timescale 1ns/1ps
module clk_gate_ctrl_sva
  import clk_gate_pkg::*;
#(
  parameter int         NGROUPS  = NUM_GROUPS,
  parameter logic [6:0] CAL_TRIM = CAL_TRIM_RESET
) (
  // Clock, reset, register port
  input wire logic               clk_in,
  input wire logic               nrst_in,
  input wire logic               ce_in,
  input wire logic [7:0]         sfr_addr_in,
  input wire logic [7:0]         sfr_wdata_in,
  input wire logic               sfr_wr_in,
  input wire logic               sfr_rd_in,
  input wire logic [7:0]         sfr_rdata_out,
  // Core state and outputs
  input wire logic               core_idle_in,
  input wire logic               clk_req_in,
  input wire logic [NGROUPS-1:0] periph_clk_en_out,
  input wire logic               lp_active_out,
  input wire logic               lp_idle_out,
  input wire logic               src_clk_req_out,
  input wire logic               hf_osc_enable_out,
  input wire logic               spread_spectrum_enable_out,
  input wire logic [CAL_MSB:0]   hf_osc_cal_out
);
  logic [7:0]         pclk_q;
  logic [7:0]         cal_q;
  logic [2:0]         mode_q;
  logic               osc_q;
  logic [NGROUPS-1:0] exp_en;
  wire                wr_ok = ce_in && sfr_wr_in;
  wire                rd_ok = ce_in && sfr_rd_in;
  wire                unmapped = !(sfr_addr_in inside {8'hAF, 8'hB2, 8'hF6, 8'hF7});
  // Shadow registers; reserved mode bits are never kept
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pclk_q <= 8'h00;
      mode_q <= 3'h0;
      cal_q  <= {1'b0, CAL_TRIM};
      osc_q  <= 1'b0;
    end else if (wr_ok) begin
      if (sfr_addr_in == 8'hF6) pclk_q <= sfr_wdata_in;
      if (sfr_addr_in == 8'hF7) mode_q <= sfr_wdata_in[2:0];
      if (sfr_addr_in == 8'hAF) cal_q <= sfr_wdata_in;
      if (sfr_addr_in == 8'hB2) osc_q <= sfr_wdata_in[7];
    end
  end
  // Expected group enables: all run unless low power is on
  always_comb begin
    if (!mode_q[2]) exp_en = '1;
    else if (core_idle_in) exp_en = pclk_q[3:0];
    else if (mode_q[0]) exp_en = '1;
    else exp_en = pclk_q[7:4];
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  chk_group_enable: assert property (ce_in |=> periph_clk_en_out == $past(exp_en))
    else $error("group enables wrong");
  chk_lp_idle_mode: assert property (lp_idle_out == (mode_q[2] && core_idle_in))
    else $error("low power idle decode wrong");
  chk_lp_active_mode: assert property (lp_active_out == (mode_q[2] && !core_idle_in))
    else $error("low power active decode wrong");
  chk_req_free_run: assert property (ce_in && !mode_q[1] |=> src_clk_req_out)
    else $error("source request dropped");
  chk_req_incoming: assert property (ce_in && mode_q[1] && clk_req_in |=> src_clk_req_out)
    else $error("incoming request not passed");
  chk_req_idle_off: assert property (ce_in && mode_q[1] && !clk_req_in && periph_clk_en_out == 0
    && exp_en == 0 |=> !src_clk_req_out)
    else $error("source request not released");
  chk_osc_outputs: assert property (hf_osc_cal_out == cal_q[6:0] && hf_osc_enable_out == osc_q
    && spread_spectrum_enable_out == cal_q[7])
    else $error("oscillator controls wrong");
  chk_read_pclk: assert property (rd_ok && sfr_addr_in == 8'hF6 |=>
    sfr_rdata_out == $past(pclk_q))
    else $error("enable register read wrong");
  chk_read_mode: assert property (rd_ok && sfr_addr_in == 8'hF7 |=>
    sfr_rdata_out == {5'h00, $past(mode_q)})
    else $error("mode register read wrong");
  chk_read_unmapped: assert property (rd_ok && unmapped |=> sfr_rdata_out == 8'h00)
    else $error("unmapped read not zero");
  cover property (lp_idle_out && periph_clk_en_out != '1);
  cover property (lp_active_out && mode_q[0]);
  cover property (mode_q[1] && !src_clk_req_out);
endmodule : clk_gate_ctrl_sva

// >>> test/clk_domain_model.sv
// Far side model: oscillator lock and gated clock edge counters
`timescale 1ns/1ps
module clk_domain_model #(
  parameter int LOCK_DLY = 3
) (
  // Inputs from the block
  input  wire logic       clk_in,
  input  wire logic       osc_en_in,
  input  wire logic [3:0] gclk_in,
  input  wire logic       clr_in,
  // Lock flag and edge counts
  output logic            locked_out,
  output logic [3:0][7:0] edges_out
);
  logic [3:0] lock_cnt;
  // Lock only after running a while; drops at once when disabled
  always @(posedge clk_in) begin
    if (!osc_en_in) lock_cnt <= 4'h0;
    else if (lock_cnt != 4'hF) lock_cnt <= lock_cnt + 4'h1;
  end
  assign locked_out = osc_en_in && (lock_cnt >= LOCK_DLY);
  // Count every rising edge, so a runt pulse shows as an extra edge
  for (genvar g = 0; g < 4; g++) begin : g_cnt
    always @(posedge gclk_in[g] or posedge clr_in) begin
      if (clr_in) edges_out[g] <= 8'h00;
      else edges_out[g] <= edges_out[g] + 8'h01;
    end
  end
endmodule : clk_domain_model

// >>> test/tb_clk_gate_ctrl.sv
// Self-checking bench for the clock gating block
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin fails++; \
  $display("[FAIL] %s expected %0h seen %0h", n, e, g); end end
module tb_clk_gate_ctrl;
  import clk_gate_pkg::*;
  typedef struct {logic [7:0] mode; logic [7:0] pclk; logic idle; logic [3:0] en;} row_s;
  row_s rows[7] = '{'{8'h00, 8'h00, 1'b0, 4'hF}, '{8'h04, 8'hA5, 1'b0, 4'hA},
    '{8'h04, 8'hA5, 1'b1, 4'h5}, '{8'h04, 8'h5A, 1'b0, 4'h5}, '{8'h04, 8'h5A, 1'b1, 4'hA},
    '{8'h05, 8'h00, 1'b0, 4'hF}, '{8'h05, 8'h0C, 1'b1, 4'hC}};
  logic clk_in, nrst_in, ce_in, sfr_wr_in, sfr_rd_in, core_idle_in, clk_req_in, clr, scan;
  logic lp_active_out, lp_idle_out, src_clk_req_out, hf_osc_enable_out, spread_spectrum_enable, locked;
  logic [7:0] sfr_addr_in, sfr_wdata_in, sfr_rdata_out, rv;
  logic [3:0] periph_clk_out, periph_clk_en_out;
  logic [6:0] cal;
  logic [3:0][7:0] edges;
  int fails, check_count, k;
  clk_gate_ctrl #(.SETTLE_CYCLES(5)) i_clk_gate_ctrl (.clk_in, .nrst_in, .ce_in,
    .sfr_addr_in, .sfr_wdata_in, .sfr_wr_in, .sfr_rd_in, .sfr_rdata_out, .core_idle_in,
    .clk_req_in, .scan_en_in(scan), .periph_clk_out, .periph_clk_en_out, .lp_active_out,
    .lp_idle_out, .src_clk_req_out, .hf_osc_enable_out, .spread_spectrum_enable_out(spread_spectrum_enable),
    .hf_osc_cal_out(cal), .hf_osc_locked_in(locked));
  clk_domain_model i_clk_domain_model (.clk_in, .osc_en_in(hf_osc_enable_out),
    .gclk_in(periph_clk_out), .clr_in(clr), .locked_out(locked), .edges_out(edges));
  // Free-running system clock
  initial begin
    clk_in = 0;
    forever #5 clk_in = ~clk_in;
  end
  // One register access, held for one edge
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    sfr_wr_in = w;
    sfr_rd_in = !w;
    sfr_addr_in = a;
    sfr_wdata_in = d;
    @(negedge clk_in);
    rv = sfr_rdata_out;
  endtask : acc
  task automatic quiet(input int n);
    sfr_wr_in = 0;
    sfr_rd_in = 0;
    repeat (n) @(negedge clk_in);
  endtask : quiet
  task automatic poll_ready;
    for (k = 0; k < 40 && rv !== 8'hC0; k++) acc(0, 8'hB2, 8'h00);
    `CHK("ready", 8'hC0, rv)
  endtask : poll_ready
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_sim
  // Hang guard, far beyond the expected run
  initial begin
    #200000;
    fails++;
    end_sim();
  end
  initial begin
    {nrst_in, core_idle_in, clk_req_in, clr, sfr_wr_in, sfr_rd_in} = 6'h00;
    {sfr_addr_in, sfr_wdata_in} = 16'h0000;
    ce_in = 1;
    scan = 0;
    fails = 0;
    check_count = 0;
    repeat (4) @(negedge clk_in);
    nrst_in = 1;
    repeat (3) @(negedge clk_in);
    acc(0, 8'hF6, 8'h00); `CHK("lowpower_periph_clock_enable", 8'h00, rv)
    acc(0, 8'hF7, 8'h00); `CHK("mode", 8'h00, rv)
    acc(0, 8'hAF, 8'h00); `CHK("cal", {1'b0, CAL_TRIM_RESET}, rv)
    acc(0, 8'hB2, 8'h00); `CHK("oscctl", 8'h00, rv)
    `CHK("reset_en", 4'hF, periph_clk_en_out)
    $display("reset test done");
    // Gating table with edge counts per group
    foreach (rows[i]) begin
      acc(1, 8'hF7, rows[i].mode);
      acc(1, 8'hF6, rows[i].pclk);
      core_idle_in = rows[i].idle;
      quiet(2);
      `CHK("group_en", rows[i].en, periph_clk_en_out)
      `CHK("lp_idle", rows[i].mode[2] & rows[i].idle, lp_idle_out)
      clr = 1;
      @(negedge clk_in);
      clr = 0;
      repeat (8) @(negedge clk_in);
      for (k = 0; k < 4; k++) `CHK("edges", rows[i].en[k] ? 8'h08 : 8'h00, edges[k])
      $display("gating row %0d done", i);
    end
    // Source clock request gating
    core_idle_in = 0;
    acc(1, 8'hF7, 8'h06);
    acc(1, 8'hF6, 8'h00);
    quiet(3);
    `CHK("req_off", 1'b0, src_clk_req_out)
    clk_req_in = 1;
    quiet(2);
    `CHK("req_in", 1'b1, src_clk_req_out)
    clk_req_in = 0;
    // Scan enable runs every clock although all groups are gated
    scan = 1;
    clr = 1;
    @(negedge clk_in);
    clr = 0;
    repeat (8) @(negedge clk_in);
    for (k = 0; k < 4; k++) `CHK("scan_edges", 8'h08, edges[k])
    scan = 0;
    $display("request test done");
    // Reserved bits, unmapped place, frozen enable
    acc(1, 8'hF7, 8'hFF);
    acc(0, 8'hF7, 8'h00); `CHK("mode_rsvd", 8'h07, rv)
    acc(1, 8'h10, 8'h55);
    acc(0, 8'h10, 8'h00); `CHK("unmapped", 8'h00, rv)
    ce_in = 0;
    acc(1, 8'hF6, 8'h33);
    ce_in = 1;
    acc(0, 8'hF6, 8'h00); `CHK("frozen", 8'h00, rv)
    acc(1, 8'hF7, 8'h00);
    $display("refusal test done");
    // Oscillator enable by read-modify-write; bias lives outside this block
    // bias assumed set before enable
    acc(0, 8'hB2, 8'h00);
    acc(1, 8'hB2, rv | 8'h80);
    acc(0, 8'hB2, 8'h00); `CHK("not_ready", 8'h80, rv)
    poll_ready();
    acc(1, 8'hAF, 8'hBF);
    acc(0, 8'hB2, 8'h00); `CHK("restart", 8'h80, rv)
    `CHK("cal_out", 7'h3F, cal)
    `CHK("dither", 1'b1, spread_spectrum_enable)
    poll_ready();
    acc(1, 8'hAF, 8'h00); acc(0, 8'hAF, 8'h00); `CHK("cal_min", 8'h00, rv)
    acc(1, 8'hAF, 8'h7F); acc(0, 8'hAF, 8'h00); `CHK("cal_max", 8'h7F, rv)
    acc(0, 8'hB2, 8'h00);
    acc(1, 8'hB2, rv & 8'h7F);
    acc(0, 8'hB2, 8'h00); `CHK("osc_off", 8'h00, rv)
    quiet(1);
    $display("oscillator test done");
    end_sim();
  end
endmodule : tb_clk_gate_ctrl
bind clk_gate_ctrl clk_gate_ctrl_sva #(.NGROUPS(NGROUPS), .CAL_TRIM(CAL_TRIM))
  i_clk_gate_ctrl_sva (.clk_in, .nrst_in, .ce_in, .sfr_addr_in, .sfr_wdata_in, .sfr_wr_in,
  .sfr_rd_in, .sfr_rdata_out, .core_idle_in, .clk_req_in, .periph_clk_en_out, .lp_active_out,
  .lp_idle_out, .src_clk_req_out, .hf_osc_enable_out, .spread_spectrum_enable_out,
  .hf_osc_cal_out);
